// File: design/sms_memory_regs.vh
// Constants for the bus-memory slave: addresses, fields, commands and timing
`ifndef SMS_MEMORY_REGS_VH
`define SMS_MEMORY_REGS_VH

// Slave address: fixed upper five bits, pins give the lower two
`define SMS_ADDR_FIXED      5'b00101

// Register offsets reached through the index pointer
`define SMS_REG_CFG_UPDATE  8'h90
`define SMS_REG_RELOAD      8'hd8
`define SMS_REG_MAKER       8'hf4
`define SMS_REG_REVISION    8'hf5
`define SMS_REG_BRAND1      8'hf6
`define SMS_REG_BRAND2      8'hf7
`define SMS_RAM_LAST        8'hdf

// Field positions
`define SMS_ERASE_EN_BIT    2
`define SMS_RELOAD_BIT      0

// Nonvolatile window F800h..FBFFh: upper six pointer bits
`define SMS_NV_TAG          6'h3e
`define SMS_NV_HI_FIRST     8'hf8
`define SMS_NV_HI_LAST      8'hfb
`define SMS_NV_BLANK        8'hff
`define SMS_SE_BASE         10'h200
`define SMS_PAGE_BYTES      32
`define SMS_SE_LAST_STATE   6'h3e

// Command codes
`define SMS_CMD_BLOCK_WR    8'hfc
`define SMS_CMD_BLOCK_RD    8'hfd
`define SMS_CMD_ERASE       8'hfe
`define SMS_BLOCK_COUNT     8'h20

// Timing, in their own units, and derived cycle counts
`define SMS_CLK_MHZ         10
`define SMS_BOOT_US         1000
`define SMS_SE_FETCH_US     20
`define SMS_ERASE_MS        20
`define SMS_BOOT_CYC        (`SMS_BOOT_US * `SMS_CLK_MHZ)
`define SMS_SE_FETCH_CYC    (`SMS_SE_FETCH_US * `SMS_CLK_MHZ)
`define SMS_ERASE_CYC       (`SMS_ERASE_MS * 1000 * `SMS_CLK_MHZ)

`endif

// File: design/sms_memory_slave.v
// Two-wire slave with index pointer, config RAM, nonvolatile cells and state fetch
`timescale 1ns/1ns
`default_nettype none
`include "sms_memory_regs.vh"
module sms_memory_slave #(
  parameter BOOT_CYC  = `SMS_BOOT_CYC,
  parameter ERASE_CYC = `SMS_ERASE_CYC,
  parameter [7:0] MAKER_ID = 8'h5a,   // Arbitrary value
  parameter [7:0] REVISION = 8'h01,   // Arbitrary value
  parameter [7:0] BRAND1   = 8'h00,   // Arbitrary value
  parameter [7:0] BRAND2   = 8'h00    // Arbitrary value
) (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst,
  // Serial bus pins, open drain
  input  wire        i_scl,
  output reg         o_scl_out,
  output reg         o_scl_oe_n,
  input  wire        i_sda,
  output reg         o_sda_out,
  output reg         o_sda_oe_n,
  // Address-select pins
  input  wire        i_address_select_high,
  input  wire        i_address_select_low,
  // Sequencing engine side
  input  wire        i_se_advance,
  output reg  [63:0] o_se_state_word,
  output reg  [5:0]  o_se_state_index,
  output reg         o_se_loading,
  // Status
  output reg         o_busy
);
  localparam SE_FETCH_CYC = `SMS_SE_FETCH_CYC;
  localparam [7:0] BLK_CNT = `SMS_BLOCK_COUNT;
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_RX   = 6'b000010;
  localparam [5:0] ST_ACK  = 6'b000100;
  localparam [5:0] ST_LOAD = 6'b001000;
  localparam [5:0] ST_TX   = 6'b010000;
  localparam [5:0] ST_RACK = 6'b100000;

  // Storage: volatile registers and the two nonvolatile cells (never reset)
  reg [7:0] ram_mem [0:223];
  reg [7:0] nv_mem  [0:1023];

  // Pin synchronisers
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg ah_s1, ah_s2, al_s1, al_s2;

  // Protocol state
  reg [5:0] st;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] txreg;
  reg       first;
  reg       rw;
  reg       mack;
  reg       first_data;
  reg       cnt_sent;
  reg       cnt_now;
  reg       rd_adv;
  reg       push_valid;
  reg [8:0] push_data;

  // Memory engine state
  reg [15:0] ptr;
  reg [1:0]  wstep;
  reg        blk_wr;
  reg        blk_rd;
  reg        copy_on;
  reg [7:0]  copy_idx;
  reg        booting;
  reg [31:0] boot_cnt;
  reg        erasing;
  reg [31:0] erase_cnt;
  reg [4:0]  erase_page;
  reg [31:0] se_cnt;
  reg [5:0]  next_se_index;

  wire       push_ready;
  wire       f_valid;
  wire [8:0] f_data;
  wire       busy     = booting | copy_on | erasing;
  wire       f_ready  = ~copy_on & ~erasing;
  wire       nv_mode  = (ptr[15:10] == `SMS_NV_TAG);
  wire       pend     = f_valid | push_valid | rd_adv;
  wire [6:0] own_addr = {`SMS_ADDR_FIXED, ah_s2, al_s2};
  wire       scl_rise = scl_s2 & ~scl_d;
  wire       scl_fall = ~scl_s2 & scl_d;
  wire       start_c  = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire       stop_c   = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire [7:0] rd_now   = rd_byte(ptr);                                // Byte at the pointer

  // Byte seen by a read of the given address
  function [7:0] rd_byte;
    input [15:0] a;
    begin
      if (a[15:10] == `SMS_NV_TAG)
        rd_byte = nv_mem[a[9:0]];
      else if (a[15:8] != 8'h00)
        rd_byte = 8'h00;
      else if (a[7:0] <= `SMS_RAM_LAST)
        rd_byte = ram_mem[a[7:0]];
      else if (a[7:0] == `SMS_REG_MAKER)
        rd_byte = MAKER_ID;
      else if (a[7:0] == `SMS_REG_REVISION)
        rd_byte = REVISION;
      else if (a[7:0] == `SMS_REG_BRAND1)
        rd_byte = BRAND1;
      else if (a[7:0] == `SMS_REG_BRAND2)
        rd_byte = BRAND2;
      else
        rd_byte = 8'h00;
    end
  endfunction

  // Sixty-four-bit state word assembled from the state cell
  function [63:0] se_word;
    input [5:0] idx;
    integer k;
    begin
      se_word = 64'h0;
      for (k = 0; k < 8; k = k + 1)
        se_word[8*k +: 8] = nv_mem[`SMS_SE_BASE + {1'b0, idx, k[2:0]}];
    end
  endfunction

  // Two-flop synchronisers plus one delayed copy for edge finding
  always @(posedge i_clock) begin
    if (i_rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
      ah_s1  <= 1'b0;
      ah_s2  <= 1'b0;
      al_s1  <= 1'b0;
      al_s2  <= 1'b0;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
      ah_s1  <= i_address_select_high;
      ah_s2  <= ah_s1;
      al_s1  <= i_address_select_low;
      al_s2  <= al_s1;
    end
  end

  // Received bytes wait here while the memory engine is busy
  sms_pair_buffer #(
    .WIDTH (9),
    .DEPTH (2)
  ) u_rx_buffer (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_data),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready),
    .o_out_data  (f_data)
  );

  // Bus protocol engine
  always @(posedge i_clock) begin
    if (i_rst) begin
      st         <= ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      txreg      <= 8'h00;
      first      <= 1'b0;
      rw         <= 1'b0;
      mack       <= 1'b0;
      first_data <= 1'b0;
      cnt_sent   <= 1'b0;
      cnt_now    <= 1'b0;
      rd_adv     <= 1'b0;
      push_valid <= 1'b0;
      push_data  <= 9'h000;
      o_sda_out  <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_scl_out  <= 1'b0;
      o_scl_oe_n <= 1'b1;
    end else begin
      push_valid <= 1'b0;
      rd_adv     <= 1'b0;
      if (start_c) begin
        st         <= ST_RX;
        bit_cnt    <= 4'h0;
        first      <= 1'b1;
        cnt_sent   <= 1'b0;
        o_sda_oe_n <= 1'b1;
        o_scl_oe_n <= 1'b1;
      end else if (stop_c) begin
        st         <= ST_IDLE;
        o_sda_oe_n <= 1'b1;
        o_scl_oe_n <= 1'b1;
      end else begin
        case (st)
          ST_IDLE: begin
            o_sda_oe_n <= 1'b1;
            o_scl_oe_n <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shreg   <= {shreg[6:0], sda_s2};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (bit_cnt == 4'h8 && !scl_s2) begin
              if (first) begin
                if (shreg[7:1] == own_addr && !busy) begin
                  o_sda_oe_n <= 1'b0;
                  rw         <= shreg[0];
                  first_data <= ~shreg[0];
                  st         <= ST_ACK;
                end else begin
                  st <= ST_IDLE;
                end
              end else if (push_ready) begin
                push_valid <= 1'b1;
                push_data  <= {first_data, shreg};
                first_data <= 1'b0;
                o_sda_oe_n <= 1'b0;
                o_scl_oe_n <= 1'b1;
                st         <= ST_ACK;
              end else begin
                o_scl_oe_n <= 1'b0;                                  // Stretch until room
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              o_sda_oe_n <= 1'b1;
              first      <= 1'b0;
              bit_cnt    <= 4'h0;
              st         <= rw ? ST_LOAD : ST_RX;
            end
          end
          ST_LOAD: begin
            if (pend) begin
              o_scl_oe_n <= 1'b0;                                    // Wait for writes to land
            end else begin
              o_scl_oe_n <= 1'b1;
              bit_cnt    <= 4'h0;
              st         <= ST_TX;
              if (blk_rd && !cnt_sent) begin
                txreg      <= BLK_CNT;
                o_sda_oe_n <= BLK_CNT[7];
                cnt_sent   <= 1'b1;
                cnt_now    <= 1'b1;
              end else begin
                txreg      <= rd_now;
                o_sda_oe_n <= rd_now[7];
                cnt_now    <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                o_sda_oe_n <= 1'b1;
                st         <= ST_RACK;
              end else begin
                txreg      <= {txreg[6:0], 1'b0};
                o_sda_oe_n <= txreg[6];
                bit_cnt    <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise)
              mack <= ~sda_s2;
            if (scl_fall) begin
              if (mack) begin
                rd_adv <= ~cnt_now;
                st     <= ST_LOAD;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end

  // Memory engine: pointer, writes, program, erase, copy and state fetch
  always @(posedge i_clock) begin
    if (i_rst) begin
      ptr              <= 16'h0000;
      wstep            <= 2'd0;
      blk_wr           <= 1'b0;
      blk_rd           <= 1'b0;
      copy_on          <= 1'b1;
      copy_idx         <= 8'h00;
      booting          <= 1'b1;
      boot_cnt         <= 32'h0;
      erasing          <= 1'b0;
      erase_cnt        <= 32'h0;
      erase_page       <= 5'h00;
      se_cnt           <= 32'h0;
      o_se_loading     <= 1'b0;
      o_se_state_index <= 6'h00;
      o_se_state_word  <= 64'h0;
      o_busy           <= 1'b1;
    end else begin
      o_busy <= busy;
      if (rd_adv)
        ptr <= ptr + 16'h0001;
      // Power-up hold, then first state fetch
      if (booting) begin
        if (boot_cnt == BOOT_CYC - 1) begin
          booting          <= 1'b0;
          o_se_loading     <= 1'b1;
          o_se_state_index <= 6'h00;
          se_cnt           <= 32'h0;
        end else begin
          boot_cnt <= boot_cnt + 32'h1;
        end
      end
      // Copy of config pages into volatile registers
      if (copy_on) begin
        ram_mem[copy_idx] <= nv_mem[{2'b00, copy_idx}];
        copy_idx          <= copy_idx + 8'h01;
        if (copy_idx == `SMS_RAM_LAST)
          copy_on <= 1'b0;
      end
      // Page erase: blank the page, then hold off for the full time
      if (erasing) begin
        if (erase_cnt < `SMS_PAGE_BYTES)
          nv_mem[{erase_page, erase_cnt[4:0]}] <= `SMS_NV_BLANK;
        if (erase_cnt == ERASE_CYC - 1)
          erasing <= 1'b0;
        erase_cnt <= erase_cnt + 32'h1;
      end
      // State fetch timing and next-state selection
      if (o_se_loading) begin
        if (se_cnt == SE_FETCH_CYC - 1) begin
          o_se_state_word <= se_word(o_se_state_index);
          o_se_loading    <= 1'b0;
        end
        se_cnt <= se_cnt + 32'h1;
      end else if (i_se_advance && !booting) begin
        o_se_state_index <= next_se_index;
        o_se_loading     <= 1'b1;
        se_cnt           <= 32'h0;
      end
      // Bytes taken from the receive buffer
      if (f_valid && f_ready) begin
        if (f_data[8]) begin
          wstep  <= 2'd1;
          blk_wr <= 1'b0;
          blk_rd <= 1'b0;
          if (f_data[7:0] == `SMS_CMD_ERASE) begin
            if (ram_mem[`SMS_REG_CFG_UPDATE][`SMS_ERASE_EN_BIT] && nv_mode) begin
              erasing    <= 1'b1;
              erase_cnt  <= 32'h0;
              erase_page <= ptr[9:5];
            end
          end else if (f_data[7:0] == `SMS_CMD_BLOCK_WR) begin
            blk_wr <= 1'b1;
          end else if (f_data[7:0] == `SMS_CMD_BLOCK_RD) begin
            blk_rd <= 1'b1;
          end else if (f_data[7:0] >= `SMS_NV_HI_FIRST &&
                       f_data[7:0] <= `SMS_NV_HI_LAST) begin
            ptr <= {f_data[7:0], 8'h00};
          end else begin
            ptr <= {8'h00, f_data[7:0]};
          end
        end else if (wstep == 2'd1 && blk_wr) begin
          wstep <= 2'd2;                                             // Count byte ignored
        end else if (wstep == 2'd1 && nv_mode) begin
          ptr[7:0] <= f_data[7:0];
          wstep    <= 2'd2;
        end else begin
          wstep <= 2'd2;
          ptr   <= ptr + 16'h0001;
          if (nv_mode) begin
            if (nv_mem[ptr[9:0]] == `SMS_NV_BLANK)
              nv_mem[ptr[9:0]] <= f_data[7:0];
          end else if (ptr[15:8] == 8'h00 && ptr[7:0] <= `SMS_RAM_LAST) begin
            ram_mem[ptr[7:0]] <= f_data[7:0];
            if (ptr[7:0] == `SMS_REG_RELOAD && f_data[`SMS_RELOAD_BIT]) begin
              copy_on  <= 1'b1;
              copy_idx <= 8'h00;
            end
          end
        end
      end
    end
  end

  // Next state slot, skipping the reserved one
  always @* begin
    if (o_se_state_index >= `SMS_SE_LAST_STATE)
      next_se_index = 6'h00;
    else
      next_se_index = o_se_state_index + 6'h01;
  end
endmodule // sms_memory_slave
`default_nettype wire

// File: design/sms_pair_buffer.v
// Small valid/ready buffer holding received bytes for the memory engine
`timescale 1ns/1ns
`default_nettype none
module sms_pair_buffer #(
  parameter WIDTH = 9,
  parameter DEPTH = 2
) (
  // Clock and reset
  input  wire             i_clock,
  input  wire             i_rst,
  // Filling side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Draining side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PW-1:0]    wr_ptr;
  reg [PW-1:0]    rd_ptr;
  reg [PW:0]      count;

  wire do_push = i_in_valid & o_in_ready;
  wire do_pop  = o_out_valid & i_out_ready;

  assign o_in_ready  = (count != DEPTH[PW:0]);
  assign o_out_valid = (count != {(PW+1){1'b0}});
  assign o_out_data  = mem[rd_ptr];

  // Pointer and occupancy upkeep
  always @(posedge i_clock) begin
    if (i_rst) begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      count  <= {(PW+1){1'b0}};
    end else begin
      if (do_push) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr      <= (wr_ptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_pop)
        rd_ptr <= (rd_ptr == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rd_ptr + 1'b1;
      if (do_push & ~do_pop)
        count <= count + 1'b1;
      else if (do_pop & ~do_push)
        count <= count - 1'b1;
    end
  end
endmodule // sms_pair_buffer
`default_nettype wire

// File: test/sms_bus_master.sv
// Bus master model driving the two-wire link
`timescale 1ns/1ns
`default_nettype none
module sms_bus_master (
  // Clock and wire levels
  input  wire logic i_clock,
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Open-drain drives, one releases the line
  output var  logic o_scl,
  output var  logic o_sda
);
  int stalls = 0;
  // Both lines released while idle
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  // One bit: data set with clock low, sampled mid high phase, clock stretch honoured
  task automatic bit_io(input logic b, output logic r);
    int n;
    o_sda = b;
    tick(3);
    o_scl = 1'b1;
    for (n = 0; n < 4000 && i_scl !== 1'b1; n++) tick(1);
    if (n == 4000) stalls++;
    tick(2);
    r = i_sda;
    tick(2);
    o_scl = 1'b0;
    tick(1);
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start();
    o_sda = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
    tick(1);
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask
  // Byte out, most significant bit first, then the slave's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in; the last byte is not acknowledged
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // sms_bus_master
`default_nettype wire

// File: test/sms_memory_slave_sva.sv
// Concurrent checks on the bus-memory slave ports
`timescale 1ns/1ns
`default_nettype none
module sms_memory_slave_sva (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  // Bus pins
  input wire logic        i_scl,
  input wire logic        o_scl_out,
  input wire logic        o_scl_oe_n,
  input wire logic        o_sda_out,
  input wire logic        o_sda_oe_n,
  // State engine and status
  input wire logic [63:0] o_se_state_word,
  input wire logic [5:0]  o_se_state_index,
  input wire logic        o_se_loading,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic in_boot;
  // Marks the hold-off from reset until the first idle cycle
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      in_boot <= 1'b1;
    end else if (!o_busy) begin
      in_boot <= 1'b0;
    end
  end
  // Named steps, each used by one property below
  sequence scl_high_run;
    i_scl [*4];
  endsequence
  sequence idle_run;
    !o_se_loading [*3];
  endsequence
  a_reset_vals: assert property (disable iff (1'b0) i_rst |=> o_sda_oe_n && o_scl_oe_n
    && o_busy && !o_se_loading && o_se_state_index == 6'h00) else $error("reset values wrong");
  a_pins_low: assert property (o_sda_out == 1'b0 && o_scl_out == 1'b0)
    else $error("open drain drive value not low");
  a_boot_busy: assert property ($fell(i_rst) |-> o_busy [*8])
    else $error("busy not held after reset");
  a_boot_nack: assert property (in_boot |-> o_sda_oe_n)
    else $error("data line driven during boot");
  a_sda_stable: assert property (scl_high_run |-> $stable(o_sda_oe_n))
    else $error("data changed while clock high");
  a_fetch_time: assert property ($rose(o_se_loading) |-> ##[190:210] $fell(o_se_loading))
    else $error("state fetch length wrong");
  a_index_load: assert property ($changed(o_se_state_index) |-> o_se_loading)
    else $error("state index moved outside a fetch");
  a_index_range: assert property (o_se_state_index != 6'h3f)
    else $error("reserved state slot used");
  a_word_hold: assert property (idle_run |-> $stable(o_se_state_word))
    else $error("state word changed outside a fetch");
endmodule // sms_memory_slave_sva
bind sms_memory_slave sms_memory_slave_sva sms_memory_slave_sva_i (.i_clock, .i_rst, .i_scl,
  .o_scl_out, .o_scl_oe_n, .o_sda_out, .o_sda_oe_n, .o_se_state_word, .o_se_state_index,
  .o_se_loading, .o_busy);
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the bus-memory slave
`timescale 1ns/1ns
`default_nettype none
`include "sms_memory_regs.vh"
module tb;
  localparam logic [6:0]  DEV = {`SMS_ADDR_FIXED, 2'b10};
  localparam logic [31:0] IDS = 32'h6b02a1b2; // Arbitrary id values, F4h first
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic        se_adv  = 1'b0;
  logic        m_scl, m_sda, scl_out, scl_oe_n, sda_out, sda_oe_n, busy, loading;
  logic [63:0] word;
  logic [5:0]  index;
  int          errors = 0;
  int          total_checks = 0;
  // Open-drain wires with pull-ups
  wire logic scl_w = m_scl & (scl_oe_n | scl_out);
  wire logic sda_w = m_sda & (sda_oe_n | sda_out);
  always #50 i_clock = ~i_clock;
  sms_bus_master sms_bus_master_i (.i_clock(i_clock), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl(m_scl), .o_sda(m_sda));
  sms_memory_slave #(.BOOT_CYC(300), .ERASE_CYC(400), .MAKER_ID(IDS[31:24]),
    .REVISION(IDS[23:16]), .BRAND1(IDS[15:8]), .BRAND2(IDS[7:0])) sms_memory_slave_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl_w), .o_scl_out(scl_out),
    .o_scl_oe_n(scl_oe_n), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
    .i_address_select_high(1'b1), .i_address_select_low(1'b0), .i_se_advance(se_adv),
    .o_se_state_word(word), .o_se_state_index(index), .o_se_loading(loading), .o_busy(busy));
  task automatic end_sim();
    errors += sms_bus_master_i.stalls;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge i_clock);
    if (n == 3000) begin
      errors++;
      end_sim();
    end
  endtask
  // Write: address, command, then nd data bytes high first
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    input int nd, output logic ok);
    logic k;
    sms_bus_master_i.start();
    sms_bus_master_i.wr_byte({a, 1'b0}, ok);
    if (ok) sms_bus_master_i.wr_byte(c, k);
    for (int i = nd - 1; i >= 0 && ok; i--) sms_bus_master_i.wr_byte(d[8*i +: 8], k);
    sms_bus_master_i.stop();
  endtask
  // Set the pointer, then read one byte
  task automatic peek(input logic [7:0] c, input logic [7:0] lo, input int nd,
                      output logic [7:0] d);
    logic k;
    wr(DEV, c, {8'h00, lo}, nd, k);
    sms_bus_master_i.start();
    sms_bus_master_i.wr_byte({DEV, 1'b1}, k);
    sms_bus_master_i.rd_byte(1'b1, d);
    sms_bus_master_i.stop();
  endtask
  task automatic t_boot_addr();
    logic ok;
    wr(DEV, 8'h10, 16'h0000, 0, ok);
    chk(ok, 1'b0);
    wait_idle();
    for (int p = 0; p < 4; p++) begin
      wr({`SMS_ADDR_FIXED, 2'(p)}, 8'h10, 16'h0000, 0, ok);
      chk(ok, p == 2);
    end
  endtask
  task automatic t_ram_ids();
    logic ok;
    logic [7:0] d;
    peek(8'h10, 8'h00, 0, d);
    chk(d, 8'ha5);
    wr(DEV, 8'h10, 16'h0055, 1, ok);
    peek(8'h10, 8'h00, 0, d);
    chk(d, 8'h55);
    wr(DEV, `SMS_REG_RELOAD, 16'h0001, 1, ok);
    wait_idle();
    peek(8'h10, 8'h00, 0, d);
    chk(d, 8'ha5);
    wr(DEV, `SMS_REG_MAKER, 16'h0000, 1, ok);
    for (int i = 0; i < 4; i++) begin
      peek(8'hf4 + 8'(i), 8'h00, 0, d);
      chk(d, IDS[31-8*i -: 8]);
    end
    peek(8'he0, 8'h00, 0, d);
    chk(d, 8'h00);
  endtask
  task automatic t_nv();
    logic ok;
    logic [7:0] d;
    wr(DEV, 8'hf9, 16'h203c, 2, ok);
    peek(8'hf9, 8'h20, 1, d);
    chk(d, 8'h3c);
    wr(DEV, 8'hf9, 16'h2000, 2, ok);
    peek(8'hf9, 8'h20, 1, d);
    chk(d, 8'h3c);
    wr(DEV, `SMS_REG_CFG_UPDATE, 16'h0000, 1, ok);
    wr(DEV, `SMS_CMD_ERASE, 16'h0000, 0, ok);
    wait_idle();
    peek(8'hf9, 8'h20, 1, d);
    chk(d, 8'h3c);
    wr(DEV, `SMS_REG_CFG_UPDATE, 16'h0004, 1, ok);
    wr(DEV, 8'hf9, 16'h003f, 1, ok);
    wr(DEV, `SMS_CMD_ERASE, 16'h0000, 0, ok);
    wr(DEV, 8'h10, 16'h0000, 0, ok);
    chk(ok, 1'b0);
    wait_idle();
    peek(8'hf9, 8'h20, 1, d);
    chk(d, 8'hff);
    peek(8'hf9, 8'h3f, 1, d);
    chk(d, 8'hff);
    peek(8'hf9, 8'h40, 1, d);
    chk(d, 8'h22);
  endtask
  task automatic t_se();
    int n;
    for (n = 0; n < 500 && loading !== 1'b0; n++) @(negedge i_clock);
    chk(word, 64'h0807060504030201);
    chk(index, 6'h00);
    se_adv = 1'b1;
    @(negedge i_clock);
    se_adv = 1'b0;
    for (n = 0; n < 20 && loading !== 1'b1; n++) @(negedge i_clock);
    chk(loading, 1'b1);
    for (n = 0; n < 500 && loading !== 1'b0; n++) @(negedge i_clock);
    chk(word, 64'h1716151413121110);
    chk(index, 6'h01);
  endtask
  // Preload the nonvolatile cells, release reset, run the scenarios
  initial begin
    for (int i = 0; i < 1024; i++) sms_memory_slave_i.nv_mem[i] = (i < 224) ? 8'h00 : 8'hff;
    sms_memory_slave_i.nv_mem[16] = 8'ha5;
    sms_memory_slave_i.nv_mem[319] = 8'h11;
    sms_memory_slave_i.nv_mem[320] = 8'h22;
    for (int k = 0; k < 8; k++) sms_memory_slave_i.nv_mem[512+k] = 8'(k + 1);
    for (int k = 0; k < 8; k++) sms_memory_slave_i.nv_mem[520+k] = 8'(k + 16);
    repeat (12) @(negedge i_clock);
    i_rst = 1'b0;
    t_boot_addr();
    t_ram_ids();
    t_nv();
    t_se();
    end_sim();
  end
endmodule // tb
`default_nettype wire
